// ==== pkg/conv_cfg_pkg.sv ====
// constants shared by the conversion configuration registers and the conversion scheduler
package conv_cfg_pkg;
  localparam int BYTE_W = 8;
  localparam int SCHED_W = 3;
  // scratchpad offsets and reset values
  localparam logic [7:0] SETUP_OFFSET = 8'h04;
  localparam logic [7:0] LINK_OFFSET = 8'h05;
  localparam logic [7:0] SETUP_RESET = 8'h70;
  localparam logic [7:0] LINK_RESET = 8'h80;
  localparam logic [7:0] READ_MISS = 8'h00;
  // conversion_setup field positions
  localparam int FMT_BIT = 7;
  localparam int RSVD_BIT = 6;
  localparam int DUR_BIT = 5;
  localparam int ALERT_BIT = 4;
  localparam int AVG_BIT = 3;
  localparam int SCHED_MSB = 2;
  localparam int SCHED_LSB = 0;
  // link_and_protection_setup field positions
  localparam int FAST_BIT = 7;
  localparam int SRC_MSB = 6;
  localparam int SRC_LSB = 5;
  localparam int ARB_MSB = 4;
  localparam int ARB_LSB = 3;
  localparam int HYST_MSB = 2;
  localparam int HYST_LSB = 1;
  localparam int LOCK_BIT = 0;
  // schedule codes while bus powered
  localparam logic [2:0] SCHED_ONE_SHOT = 3'h0;
  localparam logic [2:0] SCHED_STACKED = 3'h1;
  localparam logic [2:0] SCHED_AUTO = 3'h2;
  localparam logic [2:0] AVG_LAST = 3'h7;
  localparam logic [4:0] HYST_STEP_DEGC = 5'h05;
  // timing: one tick every TICK_US microseconds
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_US = 500;
  localparam int TICK_CYCLES_DEFAULT = (TICK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_SHORT_US = 3000;
  localparam int CONV_LONG_US = 5500;
  localparam logic [3:0] CONV_SHORT_TICKS = 4'(CONV_SHORT_US / TICK_US);
  localparam logic [3:0] CONV_LONG_TICKS = 4'(CONV_LONG_US / TICK_US);
  localparam int PERIOD_MAX_MS = 8000;
  localparam logic [13:0] PERIOD_MAX_TICKS = 14'(PERIOD_MAX_MS * 1000 / TICK_US);
  localparam int STAGGER_US = 500;
  localparam logic [7:0] STAGGER_TICKS = 8'((STAGGER_US + TICK_US - 1) / TICK_US);
endpackage

// ==== verilog/conv_scheduler.sv ====
// conversion scheduler: start sources, stagger delay, timed conversions and averaging
`timescale 1ns/10ps
module conv_scheduler #(
  parameter int unsigned TICK_CYCLES = conv_cfg_pkg::TICK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // settings
  input wire logic i_convert_cmd,
  input wire logic i_supply_powered,
  input wire logic [conv_cfg_pkg::SCHED_W-1:0] i_schedule,
  input wire logic i_duration_long,
  input wire logic i_averaging,
  input wire logic i_format,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_short_address,
  // conversion status
  output logic o_busy,
  output logic o_adc_running,
  output logic o_sample_done,
  output logic o_result_ready,
  output logic o_format,
  output logic o_averaging
);
  import conv_cfg_pkg::*;

  typedef enum logic [1:0] {IDLE, STAGGER, CONVERT} sched_state_t;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  function automatic logic [13:0] period_ticks(input logic [2:0] code);
    period_ticks = PERIOD_MAX_TICKS >> (code - 3'h1);
  endfunction

  function automatic logic [3:0] conv_ticks(input logic long_sel);
    conv_ticks = long_sel ? CONV_LONG_TICKS : CONV_SHORT_TICKS;
  endfunction

  sched_state_t state;
  logic [15:0] tick_cnt;
  logic [13:0] period_cnt;
  logic [15:0] wait_cnt;
  logic [3:0] conv_cnt;
  logic [2:0] samples;
  logic dur_long;

  wire tick = tick_cnt == TICK_LAST;
  wire periodic = i_supply_powered && i_schedule != SCHED_ONE_SHOT;
  wire stacked = !i_supply_powered && i_schedule == SCHED_STACKED;
  wire auto_run = !i_supply_powered && i_schedule == SCHED_AUTO;
  wire period_due = periodic && tick && period_cnt == 14'h0001;
  wire start_req = state == IDLE && ((i_convert_cmd && !periodic) || period_due || auto_run);
  wire conv_end = state == CONVERT && tick && conv_cnt == 4'h1;
  wire last_sample = !o_averaging || samples == AVG_LAST;
  wire [15:0] stagger_delay = 16'(i_short_address * STAGGER_TICKS);

  assign o_busy = state != IDLE;
  assign o_adc_running = state == CONVERT;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      period_cnt <= PERIOD_MAX_TICKS;
    end else if (!periodic || period_due) begin
      period_cnt <= period_ticks(i_schedule);
    end else if (tick) begin
      period_cnt <= period_cnt - 14'h0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= IDLE;
      wait_cnt <= 16'h0000;
      conv_cnt <= 4'h0;
      samples <= 3'h0;
      dur_long <= 1'b0;
      o_format <= 1'b0;
      o_averaging <= 1'b0;
      o_sample_done <= 1'b0;
      o_result_ready <= 1'b0;
    end else begin
      o_sample_done <= conv_end;
      o_result_ready <= conv_end && last_sample;
      unique case (state)
        IDLE: begin
          if (start_req) begin
            dur_long <= i_duration_long;
            o_format <= i_format;
            o_averaging <= i_averaging;
            samples <= 3'h0;
            conv_cnt <= conv_ticks(i_duration_long);
            wait_cnt <= stagger_delay;
            state <= stacked ? STAGGER : CONVERT;
          end
        end
        STAGGER: begin
          if (wait_cnt == 16'h0000) begin
            state <= CONVERT;
          end else if (tick) begin
            wait_cnt <= wait_cnt - 16'h0001;
          end
        end
        CONVERT: begin
          if (conv_end) begin
            if (last_sample) begin
              state <= IDLE;
            end else begin
              samples <= samples + 3'h1;
              conv_cnt <= conv_ticks(dur_long);
            end
          end else if (tick) begin
            conv_cnt <= conv_cnt - 4'h1;
          end
        end
      endcase
    end
  end
endmodule // conv_scheduler

// ==== verilog/conversion_config_registers.sv ====
// conversion configuration registers of the first scratchpad with their conversion control
`timescale 1ns/10ps
module conversion_config_registers #(
  parameter int unsigned TICK_CYCLES = conv_cfg_pkg::TICK_CYCLES_DEFAULT
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // scratchpad write from the link layer
  input wire logic i_wr_strobe,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_wr_offset,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_wr_data,
  // scratchpad read from the link layer
  input wire logic i_rd_strobe,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_rd_offset,
  output logic [conv_cfg_pkg::BYTE_W-1:0] o_rd_data,
  output logic o_rd_hit,
  // link events
  input wire logic i_crc_read_done,
  input wire logic i_std_speed_reset,
  // configuration eeprom
  input wire logic i_copy_scratchpad,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_nv_setup,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_nv_link,
  output logic o_nv_write,
  output logic [conv_cfg_pkg::BYTE_W-1:0] o_nv_setup,
  output logic [conv_cfg_pkg::BYTE_W-1:0] o_nv_link,
  // power and conversion requests
  input wire logic i_supply_powered,
  input wire logic i_convert_cmd,
  input wire logic [conv_cfg_pkg::BYTE_W-1:0] i_short_address,
  // link and protection settings
  output logic o_fast_speed_enable,
  output logic o_lock_active,
  output logic [1:0] o_short_id_source_select,
  output logic o_source_change,
  output logic [1:0] o_arbitration_mode,
  output logic [4:0] o_hysteresis_degc,
  // alert settings
  output logic o_alert_pin_enable,
  output logic o_alert_comparator_mode,
  // conversion status
  output logic o_result_format_select,
  output logic o_averaging_select,
  output logic o_conv_busy,
  output logic o_adc_running,
  output logic o_sample_done,
  output logic o_result_ready
);
  import conv_cfg_pkg::*;

  logic [1:0] rst_sync;
  wire rst_n = rst_sync[1];

  logic loaded;
  logic [7:0] setup;
  logic [3:0] arb_hyst;
  logic lock;
  logic fast;
  logic fast_pending;
  logic [1:0] src_sel;

  wire setup_hit = i_wr_offset == SETUP_OFFSET;
  wire link_hit = i_wr_offset == LINK_OFFSET;
  wire wr_open = i_wr_strobe && loaded && !lock;
  wire setup_wr = wr_open && setup_hit;
  wire link_wr = wr_open && link_hit;
  wire [1:0] wr_src = i_wr_data[SRC_MSB:SRC_LSB];
  wire [7:0] link_value = {fast, src_sel, arb_hyst, lock};
  wire rd_setup = i_rd_offset == SETUP_OFFSET;
  wire rd_link = i_rd_offset == LINK_OFFSET;
  wire [7:0] rd_value = rd_setup ? setup : (rd_link ? link_value : READ_MISS);
  wire [1:0] hyst_code = arb_hyst[HYST_MSB-HYST_LSB:0];
  wire fast_set = link_wr && i_wr_data[FAST_BIT];

  assign o_fast_speed_enable = fast;
  assign o_lock_active = lock;
  assign o_short_id_source_select = src_sel;
  assign o_arbitration_mode = arb_hyst[ARB_MSB-HYST_LSB:ARB_LSB-HYST_LSB];
  assign o_hysteresis_degc = 5'(HYST_STEP_DEGC * ({3'h0, hyst_code} + 5'h01));
  assign o_alert_pin_enable = i_supply_powered;
  assign o_alert_comparator_mode = i_supply_powered && setup[ALERT_BIT];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // first cycle after release restores the saved copy
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded <= 1'b0;
      setup <= SETUP_RESET;
      arb_hyst <= LINK_RESET[ARB_MSB:HYST_LSB];
      lock <= LINK_RESET[LOCK_BIT];
      src_sel <= LINK_RESET[SRC_MSB:SRC_LSB];
      o_source_change <= 1'b0;
    end else if (!loaded) begin
      loaded <= 1'b1;
      setup <= i_nv_setup;
      arb_hyst <= i_nv_link[ARB_MSB:HYST_LSB];
      lock <= i_nv_link[LOCK_BIT];
      src_sel <= LINK_RESET[SRC_MSB:SRC_LSB];
      o_source_change <= 1'b0;
    end else begin
      o_source_change <= link_wr && wr_src != src_sel;
      if (setup_wr) begin
        setup <= i_wr_data;
      end
      if (link_wr) begin
        arb_hyst <= i_wr_data[ARB_MSB:HYST_LSB];
        src_sel <= wr_src;
        lock <= i_wr_data[LOCK_BIT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      fast <= LINK_RESET[FAST_BIT];
      fast_pending <= LINK_RESET[FAST_BIT];
    end else if (!loaded) begin
      fast <= i_nv_link[FAST_BIT];
      fast_pending <= i_nv_link[FAST_BIT];
    end else begin
      if (fast_set) begin
        fast_pending <= 1'b1;
      end else if (i_std_speed_reset) begin
        fast_pending <= 1'b0;
      end
      if (i_crc_read_done && (fast_pending || fast_set)) begin
        fast <= 1'b1;
      end else if (i_std_speed_reset) begin
        fast <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_nv_write <= 1'b0;
      o_nv_setup <= SETUP_RESET;
      o_nv_link <= LINK_RESET;
    end else begin
      o_nv_write <= i_copy_scratchpad && loaded;
      if (i_copy_scratchpad && loaded) begin
        o_nv_setup <= setup;
        o_nv_link <= {fast, 2'b00, arb_hyst, lock};
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rd_data <= READ_MISS;
      o_rd_hit <= 1'b0;
    end else if (i_rd_strobe) begin
      o_rd_data <= rd_value;
      o_rd_hit <= rd_setup || rd_link;
    end else begin
      o_rd_hit <= 1'b0;
    end
  end

  conv_scheduler #(
    .TICK_CYCLES(TICK_CYCLES)
  ) scheduler (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_convert_cmd(i_convert_cmd && loaded),
    .i_supply_powered(i_supply_powered),
    .i_schedule(setup[SCHED_MSB:SCHED_LSB]),
    .i_duration_long(setup[DUR_BIT]),
    .i_averaging(setup[AVG_BIT]),
    .i_format(setup[FMT_BIT]),
    .i_short_address(i_short_address),
    .o_busy(o_conv_busy),
    .o_adc_running(o_adc_running),
    .o_sample_done(o_sample_done),
    .o_result_ready(o_result_ready),
    .o_format(o_result_format_select),
    .o_averaging(o_averaging_select)
  );
endmodule // conversion_config_registers

// ==== dv/cfg_eeprom_model.sv ====
// configuration eeprom model holding the saved bytes
`timescale 1ns/10ps
module cfg_eeprom_model (
  // clock
  input wire logic i_clk,
  // save port
  input wire logic i_nv_write,
  input wire logic [7:0] i_nv_setup,
  input wire logic [7:0] i_nv_link,
  // saved bytes
  output logic [7:0] o_setup,
  output logic [7:0] o_link
);
  initial begin
    o_setup = 8'h70;
    o_link = 8'h80;
  end
  always @(posedge i_clk) begin
    if (i_nv_write) begin
      o_setup <= i_nv_setup;
      o_link <= i_nv_link;
    end
  end
endmodule // cfg_eeprom_model

// ==== dv/conversion_config_registers_assertions.sv ====
// checker for the conversion configuration registers
`timescale 1ns/10ps
module conversion_config_registers_assertions (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_rd_offset,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_hit,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_offset,
  input wire logic [7:0] i_wr_data,
  input wire logic i_copy_scratchpad,
  input wire logic o_nv_write,
  input wire logic [7:0] o_nv_link,
  input wire logic i_std_speed_reset,
  input wire logic o_fast_speed_enable,
  input wire logic o_lock_active,
  input wire logic [4:0] o_hysteresis_degc,
  input wire logic [1:0] o_arbitration_mode,
  input wire logic i_supply_powered,
  input wire logic o_alert_pin_enable,
  input wire logic o_alert_comparator_mode,
  input wire logic i_convert_cmd,
  input wire logic o_conv_busy,
  input wire logic o_sample_done,
  input wire logic o_result_ready
);
  logic [2:0] up;
  wire logic rdy = (up == 3'h4);
  wire logic mapped = (i_rd_offset == 8'h04) || (i_rd_offset == 8'h05);
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) up <= 3'h0;
    else if (!rdy) up <= up + 3'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_rd_req;
    rdy && i_rd_strobe;
  endsequence
  sequence s_link_wr;
    rdy && i_wr_strobe && i_wr_offset == 8'h05 && !o_lock_active;
  endsequence
  a_read_hit: assert property (s_rd_req ##0 mapped |=> o_rd_hit)
    else $error("read hit missing");
  a_read_miss: assert property (s_rd_req ##0 !mapped |=> !o_rd_hit && o_rd_data == 8'h00)
    else $error("unmapped read wrong");
  a_hit_cause: assert property (o_rd_hit |-> $past(i_rd_strobe))
    else $error("hit without read");
  a_hyst_arb_map: assert property (s_link_wr |=>
    o_hysteresis_degc == {3'h0, $past(i_wr_data[2:1])} * 5'h05 + 5'h05
    && o_arbitration_mode == $past(i_wr_data[4:3]))
    else $error("hysteresis map wrong");
  a_fast_hold: assert property (rdy && o_fast_speed_enable && !i_std_speed_reset |=> o_fast_speed_enable)
    else $error("fast speed cleared");
  a_lock_stick: assert property (rdy && o_lock_active |=> o_lock_active)
    else $error("lock cleared");
  a_copy_save: assert property (rdy && i_copy_scratchpad |=> o_nv_write && o_nv_link[6:5] == 2'h0)
    else $error("copy save wrong");
  a_alert_supply: assert property (o_alert_pin_enable == i_supply_powered
    && (!o_alert_comparator_mode || i_supply_powered))
    else $error("alert without supply");
  a_result_last: assert property (o_result_ready |-> o_sample_done && !o_conv_busy)
    else $error("result not last");
  a_start_busy: assert property (rdy && i_convert_cmd && !o_conv_busy |=> o_conv_busy)
    else $error("convert not started");
endmodule // conversion_config_registers_assertions
bind conversion_config_registers conversion_config_registers_assertions conversion_config_registers_assertions_inst (
  .i_clk, .i_resetn, .i_rd_strobe, .i_rd_offset, .o_rd_data, .o_rd_hit, .i_wr_strobe, .i_wr_offset, .i_wr_data,
  .i_copy_scratchpad, .o_nv_write, .o_nv_link, .i_std_speed_reset, .o_fast_speed_enable, .o_lock_active,
  .o_hysteresis_degc, .o_arbitration_mode, .i_supply_powered, .o_alert_pin_enable, .o_alert_comparator_mode,
  .i_convert_cmd, .o_conv_busy, .o_sample_done, .o_result_ready);

// ==== dv/conversion_config_registers_tb.sv ====
// self-checking bench for the conversion configuration registers
`timescale 1ns/10ps
module conversion_config_registers_tb;
  import conv_cfg_pkg::*;
  localparam int TC = 4;
  localparam int resistor_detect_interval = 8;
  logic i_clk = 1'b0, i_resetn = 1'b0, wr = 1'b0, rd = 1'b0, crc = 1'b0, stdr = 1'b0, cpy = 1'b0, sup = 1'b0;
  logic cvt = 1'b0;
  logic [7:0] wo = 8'h00, wd = 8'h00, ro = 8'h00, sa = 8'h00;
  wire logic [7:0] rdat, nvs, nvl, ens, enl;
  wire logic [4:0] hyst;
  wire logic hit, nvw, fast, lock, busy, sdone, rrdy, fmt, avg;
  wire logic srcc, adc, alen, alcmp;
  wire logic [1:0] sid, arb;
  int error_cnt = 0, check_count = 0, n, s;
  always #12.5 i_clk = ~i_clk;
  conversion_config_registers #(.TICK_CYCLES(TC)) conversion_config_registers_inst (
    .i_clk, .i_resetn, .i_wr_strobe(wr), .i_wr_offset(wo), .i_wr_data(wd), .i_rd_strobe(rd), .i_rd_offset(ro),
    .o_rd_data(rdat), .o_rd_hit(hit), .i_crc_read_done(crc), .i_std_speed_reset(stdr), .i_copy_scratchpad(cpy),
    .i_nv_setup(ens), .i_nv_link(enl), .o_nv_write(nvw), .o_nv_setup(nvs), .o_nv_link(nvl),
    .i_supply_powered(sup), .i_convert_cmd(cvt), .i_short_address(sa), .o_fast_speed_enable(fast),
    .o_lock_active(lock), .o_short_id_source_select(sid), .o_source_change(srcc), .o_arbitration_mode(arb),
    .o_hysteresis_degc(hyst), .o_alert_pin_enable(alen), .o_alert_comparator_mode(alcmp),
    .o_result_format_select(fmt), .o_averaging_select(avg), .o_conv_busy(busy), .o_adc_running(adc),
    .o_sample_done(sdone), .o_result_ready(rrdy));
  cfg_eeprom_model cfg_eeprom_model_inst (
    .i_clk, .i_nv_write(nvw), .i_nv_setup(nvs), .i_nv_link(nvl), .o_setup(ens), .o_link(enl));
  task automatic complete_run;
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] o, input logic [7:0] d);
    @(posedge i_clk);
    wr <= 1'b1;
    wo <= o;
    wd <= d;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] o, input logic [7:0] e, input logic h);
    @(posedge i_clk);
    rd <= 1'b1;
    ro <= o;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk_byte("rd_data", e, rdat);
    chk_bit("rd_hit", h, hit);
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk);
    cvt <= (k == 0);
    crc <= (k == 1);
    stdr <= (k == 2);
    cpy <= (k == 3);
    @(posedge i_clk);
    {cvt, crc, stdr, cpy} <= 4'h0;
    #1;
  endtask
  task automatic do_reset;
    @(posedge i_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic wait_hi(input int w);
    n = 0;
    while ((w ? rrdy : busy) !== 1'b1 && n < 1200) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    chk_bit("waited", 1'b1, n < 1200);
  endtask
  task automatic conv(input logic [7:0] cfg, input int tk, input int ns);
    wr_reg(8'h04, cfg);
    pulse(0);
    n = 0;
    s = 0;
    while (rrdy !== 1'b1 && n < 2000) begin
      @(posedge i_clk);
      #1;
      n++;
      if (sdone === 1'b1) s++;
    end
    chk_byte("samples", 8'(ns), 8'(s));
    if (ns == 1) chk_bit("duration", 1'b1, n > (tk - 1) * TC && n <= tk * TC + 2);
    chk_bit("fmt", cfg[7], fmt);
    chk_bit("avg", cfg[3], avg);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    do_reset();
    rd_chk(8'h04, 8'h70, 1'b1);
    rd_chk(8'h05, 8'h80, 1'b1);
    rd_chk(8'h07, 8'h00, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h05, 8'(i * 2));
      #1;
      chk_byte("hyst", 8'(5 * i + 5), 8'(hyst));
    end
    rd_chk(8'h05, 8'h86, 1'b1);
    pulse(2);
    chk_bit("fast", 1'b0, fast);
    wr_reg(8'h05, 8'h80);
    #1;
    chk_bit("fast", 1'b0, fast);
    pulse(1);
    chk_bit("fast", 1'b1, fast);
    wr_reg(8'h05, 8'hd8);
    #1;
    chk_bit("src_change", 1'b1, srcc);
    chk_byte("src_sel", 8'h02, 8'(sid));
    chk_byte("arb", 8'h03, 8'(arb));
    repeat (resistor_detect_interval) @(posedge i_clk);
    conv(8'h40, 6, 1);
    conv(8'h60, 11, 1);
    conv(8'hc8, 6, 8);
    sa <= 8'h03;
    conv(8'h41, 9, 1);
    wr_reg(8'h04, 8'h42);
    wait_hi(1);
    @(posedge i_clk);
    #1;
    chk_bit("auto", 1'b1, busy);
    chk_bit("adc", 1'b1, adc);
    wr_reg(8'h04, 8'h40);
    wait_hi(1);
    sup <= 1'b1;
    wr_reg(8'h04, 8'h57);
    #1;
    chk_bit("alert_en", 1'b1, alen);
    chk_bit("alert_cmp", 1'b1, alcmp);
    wait_hi(0);
    wait_hi(1);
    wait_hi(0);
    wr_reg(8'h04, 8'h40);
    wait_hi(1);
    sup <= 1'b0;
    wr_reg(8'h04, 8'h75);
    wr_reg(8'h05, 8'ha0);
    pulse(3);
    do_reset();
    rd_chk(8'h04, 8'h75, 1'b1);
    rd_chk(8'h05, 8'h80, 1'b1);
    wr_reg(8'h05, 8'h81);
    #1;
    chk_bit("lock", 1'b1, lock);
    wr_reg(8'h04, 8'h40);
    wr_reg(8'h05, 8'h80);
    rd_chk(8'h04, 8'h75, 1'b1);
    rd_chk(8'h05, 8'h81, 1'b1);
    complete_run();
  end
endmodule // conversion_config_registers_tb
